// file: logic/spc_pkg.sv
package spc_pkg;

   // Register map and count.
   localparam int SPC_REG_COUNT = 7;
   localparam logic [7:0] SPC_OFS_DEV_CONFIG = 8'h00;
   localparam logic [7:0] SPC_OFS_RX_SET = 8'h01;
   localparam logic [7:0] SPC_OFS_SPARE_02 = 8'h02;
   localparam logic [7:0] SPC_OFS_TX_PORT1 = 8'h03;
   localparam logic [7:0] SPC_OFS_TX_PORT2 = 8'h04;
   localparam logic [7:0] SPC_OFS_SPARE_05 = 8'h05;
   localparam logic [7:0] SPC_OFS_SPARE_06 = 8'h06;

   // Power-up values.
   localparam logic [7:0] SPC_RST_DEV_CONFIG = 8'hFF;
   localparam logic [7:0] SPC_RST_RX_SET = 8'h00;
   localparam logic [7:0] SPC_RST_SPARE_02 = 8'h00;
   localparam logic [7:0] SPC_RST_TX_PORT1 = 8'h00;
   localparam logic [7:0] SPC_RST_TX_PORT2 = 8'h00;
   localparam logic [7:0] SPC_RST_SPARE_05 = 8'h00;
   localparam logic [7:0] SPC_RST_SPARE_06 = 8'h0F;
   localparam logic [SPC_REG_COUNT*8-1:0] SPC_RST_ALL = {SPC_RST_SPARE_06, SPC_RST_SPARE_05,
      SPC_RST_TX_PORT2, SPC_RST_TX_PORT1, SPC_RST_SPARE_02, SPC_RST_RX_SET, SPC_RST_DEV_CONFIG};

   // Field positions of the device configuration register.
   localparam int SPC_CFG_NORMAL_BIT = 7;
   localparam int SPC_CFG_PORT1_BIT = 5;
   localparam int SPC_CFG_PORT2_BIT = 4;

   // Field positions of the receiver settings register.
   localparam int SPC_RX_PD_OFF_BIT = 7;
   localparam int SPC_RX_BIAS_VDD_BIT = 6;
   localparam int SPC_RX_BIAS_CTL_BIT = 5;
   localparam int SPC_RX_EQ_MSB = 4;
   localparam int SPC_RX_EQ_LSB = 2;
   localparam int SPC_RX_SQ_OFF_BIT = 1;

   // Fixed upper bits of the target address byte.
   localparam logic [2:0] SPC_ADDR_FIXED = 3'h5;

   // Transmit settings of one output port, laid out as the register.
   typedef struct packed {
      logic dbl_term;
      logic [2:0] emph;
      logic [1:0] swing;
      logic [1:0] slew;
   } spc_tx_t;

   // Controls sent to the input receiver.
   typedef struct packed {
      logic pulldown_on;
      logic bias_vdd;
      logic term_on;
      logic [2:0] eq;
   } spc_rx_t;

endpackage

// file: logic/spc_regfile.sv
`timescale 1ns/1ps
module spc_regfile
   import spc_pkg::*;
#(
   parameter int COUNT = SPC_REG_COUNT
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Byte write port.
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   // Byte read port, data one cycle after the address.
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   // Every register, entry 0 in the low byte.
   output logic [COUNT*8-1:0] regs
);

   // One byte per entry; a write to an unmapped offset is dropped.
   for (genvar i = 0; i < COUNT; i++) begin : g_entry
      logic [7:0] byte_q;
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            byte_q <= SPC_RST_ALL[i*8 +: 8];
         end else if (wr_en && wr_addr == 8'(i)) begin
            byte_q <= wr_data;
         end
      end
      // Each entry owns its own slice of the flat register view.
      assign regs[i*8 +: 8] = byte_q;
   end

   // Registered read; unmapped offsets read as zero.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= 8'h00;
      end else if (rd_addr < 8'(COUNT)) begin
         rd_data <= regs[rd_addr[2:0]*8 +: 8];
      end else begin
         rd_data <= 8'h00;
      end
   end

endmodule

// file: logic/spc_port_control.sv
// Behaviour
// R01 - Clock lane low squelches all output ports.
// R02 - Clock lane back restores enabled port outputs.
// R03 - Squelch detection enabled turns on input termination.
// R04 - Receiver bit 1 set disables squelch.
// R05 - Squelched port goes high impedance or pulls up.
// R06 - Port choice from enable, mode, drive, select pins.
// R07 - Source hot-plug follows mode specific sink combination.
// R08 - Port enabled only while its sink hot-plug high.
// R09 - Configuration bus is a two-wire target, 400 kb/s.
// R10 - Address byte 101, four strap bits, direction.
// R11 - Address bits taken from the four straps.
// R12 - Configuration bit 7 chooses standby or normal.
// R13 - Configuration bits 5 and 4 enable ports.
// R14 - Receiver bit 7 disconnects input pull-downs.
// R15 - Receiver bit 6 picks termination bias rail.
// R16 - Receiver bit 5 lets bit 6 steer bias.
// R17 - Receiver bits 4 to 2 set equalization.
// R18 - Transmit bit 7 open drain or double termination.
// R19 - Transmit bits 6 to 4 set pre-emphasis.
// R20 - Transmit bits 3 to 2 set swing.
// R21 - Transmit bits 1 to 0 set slew.
// R22 - Mode pin high register control, low pin control.
// R23 - Write carries offset then data; read from offset.
`timescale 1ns/1ps
module spc_port_control
   import spc_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Two-wire configuration bus.
   input wire logic serial_ctl_clock_pin,
   input wire logic serial_ctl_data_pin_i,
   output logic serial_ctl_data_pin_o,
   output logic serial_ctl_data_pin_oe,
   // Control and strap pins.
   input wire logic control_source_pin,
   input wire logic outputs_enable_pin,
   input wire logic all_ports_drive_pin,
   input wire logic port_choice_pin,
   input wire logic [3:0] strap_pins,
   // Sink hot-plug and clock lane detector.
   input wire logic hotplug_from_sink_a,
   input wire logic hotplug_from_sink_b,
   input wire logic clock_lane_present,
   // Hot-plug to the source.
   output logic hotplug_to_source,
   // Output port controls.
   output logic port_a_enable,
   output logic port_b_enable,
   output logic port_a_squelch_pullup,
   output logic port_b_squelch_pullup,
   output logic squelch_active,
   output logic standby,
   output spc_tx_t tx_a,
   output spc_tx_t tx_b,
   // Input receiver controls.
   output spc_rx_t rx_ctl
);

   typedef enum logic [2:0] {
      SPC_ST_IDLE,
      SPC_ST_ADDR,
      SPC_ST_OFFS,
      SPC_ST_WDATA,
      SPC_ST_RDATA
   } spc_state_t;

   localparam int NSYNC = 11;

   logic [NSYNC-1:0] pins_raw;
   logic [NSYNC-1:0] meta_q;
   logic [NSYNC-1:0] sync_q;
   logic scl_s;
   logic sda_s;
   logic mode_reg_s;
   logic oe_s;
   logic drive_all_s;
   logic choice_s;
   logic hpd_a_s;
   logic hpd_b_s;
   logic lane_s;
   logic [3:0] straps_s;
   logic scl_d_q;
   logic sda_d_q;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic strap_taken_q;
   logic [3:0] dev_addr_q;
   spc_state_t state_q;
   logic [3:0] bit_cnt_q;
   logic in_ack_q;
   logic [7:0] shift_q;
   logic [7:0] ptr_q;
   logic sda_low_q;
   logic wr_en;
   logic [7:0] rd_data;
   logic [SPC_REG_COUNT*8-1:0] regs;
   logic [7:0] cfg;
   logic [7:0] rxs;
   spc_tx_t reg_tx_a;
   spc_tx_t reg_tx_b;
   spc_tx_t pin_tx;
   logic sq_enabled;
   logic squelched;
   logic sel_a;
   logic sel_b;
   logic run;
   logic hotplug_to_source_d;
   logic term_d;
   logic addr_match;

   // Every pin and the lane detector pass two flip-flops.
   assign pins_raw = {serial_ctl_clock_pin, serial_ctl_data_pin_i, control_source_pin,
      outputs_enable_pin, all_ports_drive_pin, port_choice_pin, hotplug_from_sink_a,
      hotplug_from_sink_b, clock_lane_present, strap_pins[3:2]};

   // Two-stage synchroniser; the bus pins idle high.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= pins_raw;
         sync_q <= meta_q;
      end
   end

   logic [1:0] strap_lo_meta_q;
   logic [1:0] strap_lo_q;

   // Low strap pair shares its own two-stage synchroniser.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_lo_meta_q <= 2'h0;
         strap_lo_q <= 2'h0;
      end else begin
         strap_lo_meta_q <= strap_pins[1:0];
         strap_lo_q <= strap_lo_meta_q;
      end
   end

   assign {scl_s, sda_s, mode_reg_s, oe_s, drive_all_s, choice_s, hpd_a_s, hpd_b_s, lane_s} =
      sync_q[NSYNC-1:2];
   assign straps_s = {sync_q[1:0], strap_lo_q};

   // Delayed copies start at the synchroniser's reset level, so the idle-high bus gives one SCL rise after reset, seen while idle.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_d_q <= 1'b0;
         sda_d_q <= 1'b0;
      end else begin
         scl_d_q <= scl_s;
         sda_d_q <= sda_s;
      end
   end

   // R09 bus conditions
   assign scl_rise = scl_s && !scl_d_q;
   assign scl_fall = !scl_s && scl_d_q;
   assign start_cond = scl_s && scl_d_q && sda_d_q && !sda_s;
   assign stop_cond = scl_s && scl_d_q && !sda_d_q && sda_s;

   // R11 strap address capture
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_taken_q <= 1'b0;
         dev_addr_q <= 4'h0;
      end else if (!strap_taken_q && sync_q[NSYNC-1]) begin
         strap_taken_q <= 1'b1;
         dev_addr_q <= straps_s;
      end
   end

   // R10 address byte check
   assign addr_match = strap_taken_q && shift_q[7:5] == SPC_ADDR_FIXED && shift_q[4:1] == dev_addr_q;

   // R23 byte sequencing and offset pointer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= SPC_ST_IDLE;
         bit_cnt_q <= 4'h0;
         in_ack_q <= 1'b0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         sda_low_q <= 1'b0;
      end else if (stop_cond) begin
         state_q <= SPC_ST_IDLE;
         in_ack_q <= 1'b0;
         sda_low_q <= 1'b0;
      end else if (start_cond) begin
         state_q <= SPC_ST_ADDR;
         bit_cnt_q <= 4'h0;
         in_ack_q <= 1'b0;
         sda_low_q <= 1'b0;
      end else if (state_q != SPC_ST_IDLE && scl_rise) begin
         if (!in_ack_q) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end else if (state_q == SPC_ST_RDATA && sda_s) begin
            // A read not acknowledged by the host ends the transfer.
            state_q <= SPC_ST_IDLE;
         end
      end else if (state_q != SPC_ST_IDLE && scl_fall) begin
         if (in_ack_q) begin
            in_ack_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            if (state_q == SPC_ST_RDATA) begin
               shift_q <= rd_data;
               sda_low_q <= !rd_data[7];
               ptr_q <= ptr_q + 8'h01;
            end else begin
               sda_low_q <= 1'b0;
            end
         end else if (bit_cnt_q == 4'h8) begin
            in_ack_q <= 1'b1;
            case (state_q)
               SPC_ST_ADDR: begin
                  sda_low_q <= addr_match;
                  if (!addr_match) begin
                     state_q <= SPC_ST_IDLE;
                  end else if (shift_q[0]) begin
                     state_q <= SPC_ST_RDATA;
                  end else begin
                     state_q <= SPC_ST_OFFS;
                  end
               end
               SPC_ST_OFFS: begin
                  sda_low_q <= 1'b1;
                  ptr_q <= shift_q;
                  state_q <= SPC_ST_WDATA;
               end
               SPC_ST_WDATA: begin
                  sda_low_q <= 1'b1;
                  ptr_q <= ptr_q + 8'h01;
               end
               default: begin
                  sda_low_q <= 1'b0;
               end
            endcase
         end else if (state_q == SPC_ST_RDATA && bit_cnt_q != 4'h0) begin
            sda_low_q <= !shift_q[7];
         end else begin
            sda_low_q <= 1'b0;
         end
      end
   end

   // Data byte is stored as the acknowledge slot opens.
   assign wr_en = state_q == SPC_ST_WDATA && scl_fall && !in_ack_q && bit_cnt_q == 4'h8 &&
      !start_cond && !stop_cond;

   // Open-drain data line: only ever pulled low.
   assign serial_ctl_data_pin_o = 1'b0;
   assign serial_ctl_data_pin_oe = sda_low_q;

   spc_regfile #(
      .COUNT(SPC_REG_COUNT)
   ) u_regs (
      .clk(clk),
      .arst_n(arst_n),
      .wr_en(wr_en),
      .wr_addr(ptr_q),
      .wr_data(shift_q),
      .rd_addr(ptr_q),
      .rd_data(rd_data),
      .regs(regs)
   );

   assign cfg = regs[SPC_OFS_DEV_CONFIG*8 +: 8];
   assign rxs = regs[SPC_OFS_RX_SET*8 +: 8];
   assign reg_tx_a = spc_tx_t'(regs[SPC_OFS_TX_PORT1*8 +: 8]);
   assign reg_tx_b = spc_tx_t'(regs[SPC_OFS_TX_PORT2*8 +: 8]);

   // Pin control mode takes swing and pre-emphasis from the shared straps.
   always_comb begin
      pin_tx = '0;
      pin_tx.swing = straps_s[1:0];
      pin_tx.emph = {1'b0, straps_s[3:2]};
   end

   // R04 squelch disable bit
   assign sq_enabled = !rxs[SPC_RX_SQ_OFF_BIT];
   // R01 squelch on lost lane
   assign squelched = sq_enabled && !lane_s;

   // R06 port selection
   always_comb begin
      sel_a = 1'b0;
      sel_b = 1'b0;
      run = oe_s;
      if (!oe_s) begin
         sel_a = 1'b0;
      end else if (mode_reg_s) begin
         // R13 register port enables
         sel_a = cfg[SPC_CFG_PORT1_BIT];
         sel_b = cfg[SPC_CFG_PORT2_BIT];
         // R12 standby bit
         run = cfg[SPC_CFG_NORMAL_BIT];
      end else if (drive_all_s) begin
         sel_a = 1'b1;
         sel_b = 1'b1;
      end else begin
         sel_a = !choice_s;
         sel_b = choice_s;
      end
   end

   // R07 hot-plug to source
   always_comb begin
      if (!oe_s) begin
         hotplug_to_source_d = 1'b0;
      end else if (mode_reg_s) begin
         hotplug_to_source_d = (hpd_a_s && sel_a) || (hpd_b_s && sel_b);
      end else if (drive_all_s) begin
         hotplug_to_source_d = hpd_a_s || hpd_b_s;
      end else begin
         hotplug_to_source_d = choice_s ? hpd_b_s : hpd_a_s;
      end
   end

   // R03 termination with squelch
   assign term_d = sq_enabled || (oe_s && run);

   // Registered drive of every port-side output.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         port_a_enable <= 1'b0;
         port_b_enable <= 1'b0;
         port_a_squelch_pullup <= 1'b0;
         port_b_squelch_pullup <= 1'b0;
         squelch_active <= 1'b0;
         standby <= 1'b1;
         hotplug_to_source <= 1'b0;
      end else begin
         // R08 per-port hot-plug gating
         // R02 restore after squelch
         port_a_enable <= sel_a && hpd_a_s && run && !squelched;
         port_b_enable <= sel_b && hpd_b_s && run && !squelched;
         // R05 squelched port termination
         port_a_squelch_pullup <= squelched && sel_a && run && tx_a.dbl_term;
         port_b_squelch_pullup <= squelched && sel_b && run && tx_b.dbl_term;
         squelch_active <= squelched;
         standby <= !run;
         hotplug_to_source <= hotplug_to_source_d;
      end
   end

   // Transmit settings follow the control source; receiver settings come from the register, termination also from the enable pin.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_a <= '0;
         tx_b <= '0;
         rx_ctl <= '0;
      end else begin
         // R22 control source select
         // R18 output type
         // R19 pre-emphasis
         // R20 swing
         // R21 slew
         tx_a <= mode_reg_s ? reg_tx_a : pin_tx;
         tx_b <= mode_reg_s ? reg_tx_b : pin_tx;
         // R14 pull-down control
         rx_ctl.pulldown_on <= !rxs[SPC_RX_PD_OFF_BIT];
         // R15 R16 gated bias select
         rx_ctl.bias_vdd <= rxs[SPC_RX_BIAS_CTL_BIT] && rxs[SPC_RX_BIAS_VDD_BIT];
         rx_ctl.term_on <= term_d;
         // R17 equalization setting
         rx_ctl.eq <= rxs[SPC_RX_EQ_MSB:SPC_RX_EQ_LSB];
      end
   end

endmodule

// file: tb/spc_port_control_assertions.sv
`timescale 1ns/1ps
module spc_port_control_assertions
   import spc_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Pins.
   input wire logic control_source_pin,
   input wire logic outputs_enable_pin,
   input wire logic all_ports_drive_pin,
   input wire logic [3:0] strap_pins,
   input wire logic hotplug_from_sink_a,
   input wire logic hotplug_from_sink_b,
   input wire logic clock_lane_present,
   // Outputs.
   input wire logic serial_ctl_data_pin_oe,
   input wire logic hotplug_to_source,
   input wire logic port_a_enable,
   input wire logic port_b_enable,
   input wire logic port_a_squelch_pullup,
   input wire logic squelch_active,
   input wire spc_tx_t tx_a,
   input wire spc_rx_t rx_ctl
);
   logic [2:0] age_q;
   // Counts edges after reset so the pin pipeline is full before checks start.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         age_q <= 3'h0;
      end else if (age_q != 3'h5) begin
         age_q <= age_q + 3'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n || age_q != 3'h5);
   property p_sq_off; squelch_active |-> !port_a_enable && !port_b_enable; endproperty
   a_sq_off: assert property (p_sq_off) else $error("port drives while squelched");
   property p_lane_up; $past(clock_lane_present, 3) |-> !squelch_active; endproperty
   a_lane_up: assert property (p_lane_up) else $error("squelch with lane present");
   property p_sq_term; squelch_active |-> rx_ctl.term_on; endproperty
   a_sq_term: assert property (p_sq_term) else $error("termination off in squelch");
   property p_pup; port_a_squelch_pullup |-> squelch_active && $past(tx_a.dbl_term); endproperty
   a_pup: assert property (p_pup) else $error("pull-up outside squelch");
   property p_oe_off;
      !$past(outputs_enable_pin, 3) |-> !port_a_enable && !port_b_enable && !hotplug_to_source;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("output while disabled");
   property p_hpd_a; !$past(hotplug_from_sink_a, 3) |-> !port_a_enable; endproperty
   a_hpd_a: assert property (p_hpd_a) else $error("port a on without sink");
   property p_hpd_b; !$past(hotplug_from_sink_b, 3) |-> !port_b_enable; endproperty
   a_hpd_b: assert property (p_hpd_b) else $error("port b on without sink");
   property p_pin_hpd;
      !$past(control_source_pin, 3) && $past(outputs_enable_pin, 3) && $past(all_ports_drive_pin, 3)
      |-> hotplug_to_source == ($past(hotplug_from_sink_a, 3) || $past(hotplug_from_sink_b, 3));
   endproperty
   a_pin_hpd: assert property (p_pin_hpd) else $error("source hot-plug wrong");
   property p_pin_tx; !$past(control_source_pin, 3) |-> tx_a == {2'h0, $past(strap_pins, 3), 2'h0}; endproperty
   a_pin_tx: assert property (p_pin_tx) else $error("pin mode transmit wrong");
   // Main scenarios seen.
   c_sq: cover property (squelch_active);
   c_both: cover property (port_a_enable && port_b_enable);
   c_ack: cover property (serial_ctl_data_pin_oe);
endmodule
bind spc_port_control spc_port_control_assertions u_chk (.clk, .arst_n, .control_source_pin,
   .outputs_enable_pin, .all_ports_drive_pin, .strap_pins, .hotplug_from_sink_a, .hotplug_from_sink_b,
   .clock_lane_present, .serial_ctl_data_pin_oe, .hotplug_to_source, .port_a_enable, .port_b_enable,
   .port_a_squelch_pullup, .squelch_active, .tx_a, .rx_ctl);

// file: tb/spc_host_model.sv
`timescale 1ns/1ps
module spc_host_model (
   // Bench clock.
   input wire logic clk,
   // Bus wires.
   input wire logic sda_in,
   output logic scl = 1'h1,
   output logic sda_low = 1'h0
);
   // Quarter bit in clocks; 2 gives an 800 ns bus clock, 4 a slow host.
   int q = 2;
   // Drives both wires, then holds them for a quarter bit.
   task automatic drv(input logic c, input logic d);
      scl <= c;
      sda_low <= !d;
      repeat (q) @(posedge clk);
   endtask
   task automatic start;
      drv(1'h0, 1'h1);
      repeat (2) drv(1'h1, 1'h1);
      repeat (2) drv(1'h1, 1'h0);
      drv(1'h0, 1'h0);
   endtask
   task automatic stop;
      drv(1'h0, 1'h0);
      repeat (2) drv(1'h1, 1'h0);
      repeat (2) drv(1'h1, 1'h1);
   endtask
   // One bit: data set while clock low, line sampled while high.
   task automatic xb(input logic b, output logic r);
      drv(1'h0, b);
      drv(1'h1, b);
      r = sda_in;
      drv(1'h1, b);
      drv(1'h0, b);
   endtask
   // byte then acknowledge slot, most significant first
   task automatic xfer(input logic [8:0] d, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         xb(d[i], r[i]);
      end
   endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import spc_pkg::*;
   // Clock, reset and pins.
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   logic mode = 1'h1;
   logic oe_pin = 1'h1;
   logic drive = 1'h0;
   logic choice = 1'h0;
   logic [3:0] strap = 4'hA;
   logic hpa = 1'h1;
   logic hpb = 1'h1;
   logic lane = 1'h1;
   logic sda_oe, sda_o, scl, host_low, hts, pa, pb, pua, pub, sq, stby;
   spc_tx_t txa, txb;
   spc_rx_t rxc;
   wire sda = !(host_low || (sda_oe && !sda_o));
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [8:0] r;
   localparam logic [7:0] ADW = {SPC_ADDR_FIXED, 4'hA, 1'h0};
   always #50 clk = ~clk;
   spc_port_control uut (.clk(clk), .arst_n(arst_n), .serial_ctl_clock_pin(scl),
      .serial_ctl_data_pin_i(sda), .serial_ctl_data_pin_o(sda_o), .serial_ctl_data_pin_oe(sda_oe),
      .control_source_pin(mode), .outputs_enable_pin(oe_pin), .all_ports_drive_pin(drive),
      .port_choice_pin(choice), .strap_pins(strap), .hotplug_from_sink_a(hpa), .hotplug_from_sink_b(hpb),
      .clock_lane_present(lane), .hotplug_to_source(hts), .port_a_enable(pa), .port_b_enable(pb),
      .port_a_squelch_pullup(pua), .port_b_squelch_pullup(pub), .squelch_active(sq), .standby(stby),
      .tx_a(txa), .tx_b(txb), .rx_ctl(rxc));
   spc_host_model host (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(host_low));
   // Compares one value and counts it.
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle;
      repeat (5) @(posedge clk);
   endtask
   task automatic wb(input logic [7:0] b);
      host.xfer({b, 1'h1}, r);
      cmp(r[0], 1'h0);
   endtask
   task automatic wr(input logic [7:0] o, input logic [7:0] d);
      host.start();
      wb(ADW);
      wb(o);
      wb(d);
      host.stop();
   endtask
   // Sets the pointer with an offset-only write, then reads one byte.
   task automatic rd(input logic [7:0] o, input logic [7:0] e);
      host.start();
      wb(ADW);
      wb(o);
      host.start();
      wb(ADW | 8'h01);
      host.xfer(9'h1FF, r);
      host.stop();
      cmp(r[8:1], e);
   endtask
   task automatic t_reset;
      host.start();
      wb(ADW | 8'h01);
      for (int i = 0; i < SPC_REG_COUNT; i++) begin
         host.xfer({8'hFF, i == SPC_REG_COUNT - 1}, r);
         cmp(r[8:1], SPC_RST_ALL[i*8+:8]);
      end
      host.stop();
      $display("test reset done");
   endtask
   task automatic t_regs;
      logic [7:0] v;
      for (int i = 0; i < 8; i++) begin
         v = {i[0], i[2:0], i[1:0], i[1:0]};
         wr(SPC_OFS_TX_PORT1, v);
         wr(SPC_OFS_TX_PORT2, ~v);
         cmp(txa, v);
         cmp(txb, ~v);
         v = {i[2:0], i[2:0], 2'h0};
         wr(SPC_OFS_RX_SET, v);
         cmp(rxc, {2'h0, !v[7], v[6] & v[5], 1'h1, v[4:2]});
      end
      rd(SPC_OFS_RX_SET, 8'hFC);
      wr(8'h07, 8'h5A);
      rd(8'h07, 8'h00);
      for (int k = 0; k < 2; k++) begin
         host.start();
         host.xfer({k ? 8'h94 : 8'hAA, 1'h1}, r);
         host.stop();
         cmp(r[0], 1'h1);
      end
      $display("test registers done");
   endtask
   task automatic t_pin;
      @(posedge clk);
      mode <= 1'h0;
      for (int i = 0; i < 16; i++) begin
         drive <= i[3];
         choice <= i[2];
         hpa <= i[1];
         hpb <= i[0];
         settle();
         cmp(pa, (i[3] | !i[2]) & i[1]);
         cmp(pb, (i[3] | i[2]) & i[0]);
         cmp(hts, i[3] ? i[1] | i[0] : i[2] ? i[0] : i[1]);
      end
      cmp(txa, {2'h0, strap, 2'h0});
      oe_pin <= 1'h0;
      settle();
      cmp({pa, pb, hts, stby}, 4'h1);
      oe_pin <= 1'h1;
      mode <= 1'h1;
      $display("test pin mode done");
   endtask
   task automatic t_regmode;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         hpa <= i[1];
         hpb <= i[0];
         wr(SPC_OFS_DEV_CONFIG, {2'h2, i[3], i[2], 4'h0});
         settle();
         cmp(pa, i[3] & i[1]);
         cmp(pb, i[2] & i[0]);
         cmp(hts, i[3] & i[1] | i[2] & i[0]);
      end
      wr(SPC_OFS_DEV_CONFIG, 8'h30);
      settle();
      cmp({pa, pb, stby}, 3'h1);
      $display("test register mode done");
   endtask
   task automatic t_squelch;
      host.q = 4;
      wr(SPC_OFS_DEV_CONFIG, 8'hB0);
      wr(SPC_OFS_TX_PORT2, 8'h00);
      host.q = 2;
      lane <= 1'h0;
      settle();
      cmp({sq, pa, pb, pua, pub, rxc.term_on}, 6'h25);
      lane <= 1'h1;
      settle();
      cmp({sq, pa, pb}, 3'h3);
      wr(SPC_OFS_RX_SET, 8'h02);
      lane <= 1'h0;
      settle();
      cmp({sq, pa, pb}, 3'h3);
      lane <= 1'h1;
      $display("test squelch done");
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic conclude;
      $display("compares %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Cuts a hung run short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         conclude();
      end
   end
   // Main sequence.
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'h1;
      repeat (5) @(posedge clk);
      t_reset();
      t_regs();
      t_pin();
      t_regmode();
      t_squelch();
      conclude();
   end
endmodule
